// >>> src/asu_uart.v
`timescale 1ns/100ps
`include "asu_regs.vh"
// Functional notes
// R1: Frame: start, eight or nine data, stop.
// R2: Line idles high.
// R3: Start bit is logic zero.
// R4: Data bits travel LSB first.
// R5: Stop bit is logic one.
// R6: Break is whole frames of zero.
// R7: Word length bit selects eight or nine.
// R8: Shifter loads only from transmit buffer.
// R9: Pin follows shifter while busy or enabled.
// R10: Whole character moves to receive buffer.
// R11: Majority vote of three samples, noise.
// R12: Both directions share format and rate.
// R13: Writing sleep bit one sleeps receiver.
// R14: Sleep blocks all receiver flags.
// R15: Software or hardware clears sleep bit.
// R16: Idle line clears sleep in idle mode.
// R17: Senders gap messages by idle frame.
// R18: Top data bit marks address character.
// R19: Address mark wakes before stop sample.
// R20: Waking character delivered with flags.
// R21: Optional divide-by-39 baud stage.
// R22: Wake select: zero idle, one address.
// R23: Nine-bit frame carries nine data bits.
// R24: Enabling transmitter queues idle preamble.
// R25: Idle after one character of ones.
// R26: Sixteen-times sample tick, bit tick derived.
module asu_uart #(
  parameter HAS_DIV39 = 1
) (
  // Clock and reset.
  input  wire        clk,
  input  wire        rst_n,
  // AXI4-Lite write address and data.
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // AXI4-Lite write response.
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // AXI4-Lite read.
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // Serial lines.
  input  wire        rxd,
  output reg         txd
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg        t8_reg;             // Transmit ninth bit.
  reg        wlen_reg;           // Nine-bit word length when set.
  reg        wake_reg;           // Wakeup method select.
  reg        txEn_reg;           // Transmitter enable.
  reg        rxEn_reg;           // Receiver enable.
  reg        sleep_reg;          // Receiver sleep bit.
  reg        brk_reg;            // Send break.
  reg [16:0] baud_reg;           // Divisor and divide-by-39 enable.
  reg [8:0]  txBuf_reg;          // Transmit data buffer.
  reg        txEmpty_reg;        // Transmit buffer empty.
  reg [8:0]  rxBuf_reg;          // Receive data buffer.
  reg        rxFull_reg;         // Receive buffer full.
  reg        idle_reg;           // Idle line flag.
  reg        ovr_reg;            // Overrun flag.
  reg        noise_reg;          // Noise flag.
  reg        frame_reg;          // Framing flag.
  reg        stRead_reg;         // Status was read; arms read-to-clear.
  reg        rxS1_reg;           // Receive synchroniser stage one.
  reg        rxS2_reg;           // Receive synchroniser stage two.

  // ----------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------
  reg [5:0]  pre_reg;            // Divide-by-39 prescaler.
  reg [15:0] div_reg;            // Main divisor counter.
  reg        tick_reg;           // Sixteen-times sample tick.
  reg [3:0]  txPh_reg;           // Divides sample tick down to bit tick.
  wire       preHit = !(HAS_DIV39 && baud_reg[`ASU_BAUD_DIV39]) ||
                      (pre_reg == `ASU_DIV39_CNT);
  wire       bitTick = tick_reg && (txPh_reg == `ASU_OVERSAMPLE);

  // Both directions count off this same tick. R12 R26
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg  <= 6'h00;
      div_reg  <= 16'h0000;
      tick_reg <= 1'b0;
      txPh_reg <= 4'h0;
    end else begin
      tick_reg <= 1'b0;
      if (HAS_DIV39 && baud_reg[`ASU_BAUD_DIV39]) begin
        pre_reg <= (pre_reg == `ASU_DIV39_CNT) ? 6'h00 : pre_reg + 6'h01; // R21
      end
      if (preHit) begin
        if (div_reg + 16'h0001 >= baud_reg[15:0]) begin
          div_reg  <= 16'h0000;
          tick_reg <= 1'b1;
        end else begin
          div_reg <= div_reg + 16'h0001;
        end
      end
      if (tick_reg) begin
        txPh_reg <= txPh_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  reg [10:0] txSh_reg;           // Frame shifter, bit 0 on the line.
  reg [3:0]  txCnt_reg;          // Bits left in current frame.
  reg        txPre_reg;          // Preamble owed.
  reg        txEnD_reg;          // Delayed enable for edge detect.
  wire       txBusy = (txCnt_reg != 4'h0);
  wire [3:0] frameLen = wlen_reg ? 4'hB : 4'hA; // R1 R23
  reg        dataWr;             // Software writes the data register.
  wire       txRise = txEn_reg && !txEnD_reg; // Enable has just been set.

  // Shifter is fed only from the buffer, a preamble or a break. R8
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txSh_reg  <= 11'h7FF;
      txCnt_reg <= 4'h0;
      txPre_reg <= 1'b0;
      txEnD_reg <= 1'b0;
      txd       <= 1'b1;
    end else begin
      txEnD_reg <= txEn_reg;
      if (txRise) begin
        txPre_reg <= 1'b1; // R24
      end
      if (bitTick) begin
        if (txCnt_reg > 4'h1) begin
          txSh_reg  <= {1'b1, txSh_reg[10:1]}; // R4
          txCnt_reg <= txCnt_reg - 4'h1;
        end else if (txEn_reg && (txPre_reg || txRise)) begin // R24
          txSh_reg  <= 11'h7FF;
          txCnt_reg <= frameLen;
          txPre_reg <= 1'b0;
        end else if (txEn_reg && brk_reg) begin
          txSh_reg  <= 11'h000; // R6
          txCnt_reg <= frameLen;
        end else if (txEn_reg && !txEmpty_reg) begin
          // Stop, optional ninth bit, data, start. R3 R5
          txSh_reg  <= wlen_reg ? {1'b1, txBuf_reg, 1'b0} : {2'h3, txBuf_reg[7:0], 1'b0};
          txCnt_reg <= frameLen;
        end else begin
          txSh_reg  <= 11'h7FF;
          txCnt_reg <= 4'h0;
        end
      end
      txd <= (txBusy || txEn_reg) ? txSh_reg[0] : 1'b1; // R2 R9
    end
  end
  wire txLoad = bitTick && !(txCnt_reg > 4'h1) && txEn_reg && !txPre_reg && !txRise &&
                !brk_reg && !txEmpty_reg;

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  localparam RX_IDLE = 3'b001;   // Waiting for a start edge.
  localparam RX_BITS = 3'b010;   // Sampling start, data and stop.
  localparam RX_DONE = 3'b100;   // One-cycle hand-over to the buffer.
  reg [2:0]  rxSt_reg;           // Receiver state.
  reg [3:0]  rxPh_reg;           // Sample phase within a bit.
  reg [3:0]  rxBit_reg;          // Bit index, 0 is start.
  reg [9:0]  rxSh_reg;           // Data bits and stop bit.
  reg [2:0]  smp_reg;            // First two of the three mid-bit samples.
  reg        rxNoise_reg;        // Noise seen in this frame.
  reg        rxPrev_reg;         // Previous synchronised level.
  reg [7:0]  idleCnt_reg;        // Sample ticks of continuous ones.
  reg        idleArm_reg;        // Line was active since last idle.
  wire [7:0] idleLen = wlen_reg ? 8'hB0 : 8'hA0; // R25
  wire [1:0] vSum = {1'b0, smp_reg[0]} + {1'b0, smp_reg[1]} + {1'b0, rxS2_reg};
  wire       vote = vSum[1]; // R11
  wire       vNoisy = (vSum != 2'h0) && (vSum != 2'h3);
  wire [3:0] lastBit = wlen_reg ? 4'hA : 4'h9;
  wire       flagOk = !sleep_reg; // R14
  wire       idleHit = (idleCnt_reg == idleLen - 8'h01) && tick_reg && rxS2_reg;
  wire       msbNow = wlen_reg ? (rxBit_reg == 4'h9) : (rxBit_reg == 4'h8);
  wire       addrWake = wake_reg && sleep_reg && (rxSt_reg == RX_BITS) && tick_reg &&
                        (rxPh_reg == 4'h9) && msbNow && vote; // R18 R19 R22
  wire       idleWake = !wake_reg && sleep_reg && idleHit && idleArm_reg; // R16 R22
  reg        rdData;             // Software reads the data register.

  // Two-flop synchroniser on the receive pin.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxS1_reg <= 1'b1;
      rxS2_reg <= 1'b1;
    end else begin
      rxS1_reg <= rxd;
      rxS2_reg <= rxS1_reg;
    end
  end

  // Frame state machine; samples at phases 7, 8, 9 of each bit.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxSt_reg    <= RX_IDLE;
      rxPh_reg    <= 4'h0;
      rxBit_reg   <= 4'h0;
      rxSh_reg    <= 10'h000;
      smp_reg     <= 3'h0;
      rxNoise_reg <= 1'b0;
      rxPrev_reg  <= 1'b1;
    end else begin
      rxPrev_reg <= rxS2_reg;
      case (rxSt_reg)
        RX_IDLE: begin
          if (rxEn_reg && rxPrev_reg && !rxS2_reg) begin
            rxSt_reg    <= RX_BITS; // R3
            rxPh_reg    <= 4'h0;
            rxBit_reg   <= 4'h0;
            rxNoise_reg <= 1'b0;
          end
        end
        RX_BITS: begin
          if (tick_reg) begin
            rxPh_reg <= rxPh_reg + 4'h1;
            if (rxPh_reg == 4'h7) smp_reg[0] <= rxS2_reg;
            if (rxPh_reg == 4'h8) smp_reg[1] <= rxS2_reg;
            if (rxPh_reg == 4'h9) begin
              rxNoise_reg <= rxNoise_reg | vNoisy;
              if (rxBit_reg == 4'h0 && vote) begin
                rxSt_reg <= RX_IDLE; // False start.
              end else if (rxBit_reg != 4'h0) begin
                rxSh_reg <= {vote, rxSh_reg[9:1]}; // R4
              end
              if (rxBit_reg == lastBit) rxSt_reg <= RX_DONE;
              rxBit_reg <= rxBit_reg + 4'h1;
            end
          end
        end
        RX_DONE: begin
          rxSt_reg <= RX_IDLE;
        end
        default: rxSt_reg <= RX_IDLE;
      endcase
    end
  end
  // Align the frame: eight-bit frames take one shift fewer and end up one place higher.
  wire [9:0] rxFrm = wlen_reg ? rxSh_reg : {1'b0, rxSh_reg[9:1]};
  wire       stopBit = wlen_reg ? rxFrm[9] : rxFrm[8]; // R5
  wire       rxDone = (rxSt_reg == RX_DONE) && flagOk && !frame_reg;

  // Idle detector counts sample ticks of unbroken ones.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idleCnt_reg <= 8'h00;
      idleArm_reg <= 1'b0;
    end else begin
      if (!rxS2_reg) begin
        idleCnt_reg <= 8'h00;
        idleArm_reg <= 1'b1;
      end else if (idleHit) begin
        idleCnt_reg <= 8'h00;
        idleArm_reg <= 1'b0;
      end else if (tick_reg) begin
        idleCnt_reg <= idleCnt_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  reg [7:0]  awA_reg;            // Latched write address.
  reg        awH_reg;            // Write address held.
  reg [31:0] wD_reg;             // Latched write data.
  reg [3:0]  wS_reg;             // Latched strobes.
  reg        wH_reg;             // Write data held.
  wire       doWr = awH_reg && wH_reg && !s_axi_bvalid;
  wire       doRd = s_axi_arvalid && s_axi_arready;
  always @* begin
    dataWr = doWr && (awA_reg == `ASU_OFF_DATA) && wS_reg[0];
    rdData = doRd && (s_axi_araddr == `ASU_OFF_DATA);
  end
  wire       clrArm = rdData && stRead_reg;

  // Bus handshakes and register writes; hardware set wins over clear.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1; s_axi_wready <= 1'b1; s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ASU_RESP_OKAY; s_axi_arready <= 1'b1; s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000; s_axi_rresp <= `ASU_RESP_OKAY;
      awA_reg <= 8'h00; awH_reg <= 1'b0; wD_reg <= 32'h00000000;
      wS_reg <= 4'h0; wH_reg <= 1'b0;
      t8_reg <= 1'b0; wlen_reg <= 1'b0; wake_reg <= 1'b0; txEn_reg <= 1'b0;
      rxEn_reg <= 1'b0; sleep_reg <= 1'b0; brk_reg <= 1'b0;
      baud_reg <= `ASU_BAUD_RST; txBuf_reg <= 9'h000; txEmpty_reg <= 1'b1;
      rxBuf_reg <= 9'h000; rxFull_reg <= 1'b0; idle_reg <= 1'b0;
      ovr_reg <= 1'b0; noise_reg <= 1'b0; frame_reg <= 1'b0; stRead_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awA_reg <= s_axi_awaddr; awH_reg <= 1'b1; s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wD_reg <= s_axi_wdata; wS_reg <= s_axi_wstrb; wH_reg <= 1'b1; s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0; s_axi_awready <= 1'b1; s_axi_wready <= 1'b1;
      end
      if (doWr) begin
        awH_reg <= 1'b0; wH_reg <= 1'b0; s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `ASU_RESP_OKAY;
        if (awA_reg == `ASU_OFF_DATA) begin
          if (wS_reg[0]) txBuf_reg <= {t8_reg, wD_reg[7:0]};
        end else if (awA_reg == `ASU_OFF_CTRL1) begin
          if (wS_reg[0]) begin
            t8_reg <= wD_reg[`ASU_C1_T8]; wlen_reg <= wD_reg[`ASU_C1_WLEN]; // R7
            wake_reg <= wD_reg[`ASU_C1_WAKE];
          end
        end else if (awA_reg == `ASU_OFF_CTRL2) begin
          if (wS_reg[0]) begin
            txEn_reg <= wD_reg[`ASU_C2_TXEN]; rxEn_reg <= wD_reg[`ASU_C2_RXEN];
            sleep_reg <= wD_reg[`ASU_C2_SLEEP]; brk_reg <= wD_reg[`ASU_C2_BRK]; // R13 R15
          end
        end else if (awA_reg == `ASU_OFF_BAUD) begin
          if (wS_reg[0]) baud_reg[7:0] <= wD_reg[7:0];
          if (wS_reg[1]) baud_reg[15:8] <= wD_reg[15:8];
          if (wS_reg[2]) baud_reg[16] <= wD_reg[16];
        end else if (awA_reg != `ASU_OFF_STATUS) begin
          s_axi_bresp <= `ASU_RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0; s_axi_arready <= 1'b1;
      end
      if (doRd) begin
        s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b1; s_axi_rresp <= `ASU_RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        if (s_axi_araddr == `ASU_OFF_DATA) begin
          s_axi_rdata[7:0] <= rxBuf_reg[7:0];
        end else if (s_axi_araddr == `ASU_OFF_CTRL1) begin
          s_axi_rdata[7:0] <= {rxBuf_reg[8], t8_reg, 1'b0, wlen_reg, wake_reg, 3'h0};
        end else if (s_axi_araddr == `ASU_OFF_CTRL2) begin
          s_axi_rdata[3:0] <= {txEn_reg, rxEn_reg, sleep_reg, brk_reg};
        end else if (s_axi_araddr == `ASU_OFF_STATUS) begin
          s_axi_rdata[7:1] <= {txEmpty_reg, !txBusy && txEmpty_reg, rxFull_reg,
                               idle_reg, ovr_reg, noise_reg, frame_reg};
        end else if (s_axi_araddr == `ASU_OFF_BAUD) begin
          s_axi_rdata[16:0] <= baud_reg;
        end else begin
          s_axi_rresp <= `ASU_RESP_SLVERR;
        end
        if (s_axi_araddr == `ASU_OFF_STATUS) stRead_reg <= 1'b1;
        else if (s_axi_araddr == `ASU_OFF_DATA) stRead_reg <= 1'b0;
      end
      if (dataWr) txEmpty_reg <= 1'b0;
      if (txLoad) txEmpty_reg <= 1'b1;
      if (clrArm) begin
        rxFull_reg <= 1'b0; idle_reg <= 1'b0; ovr_reg <= 1'b0;
        noise_reg <= 1'b0; frame_reg <= 1'b0;
      end
      if (addrWake || idleWake) sleep_reg <= 1'b0; // R15 R16 R19
      if (idleHit && idleArm_reg && flagOk) idle_reg <= 1'b1; // R14 R25
      if (rxDone) begin
        if (rxFull_reg && !clrArm) begin
          ovr_reg <= 1'b1;
        end else begin
          rxBuf_reg <= wlen_reg ? rxFrm[8:0] : {1'b0, rxFrm[7:0]}; // R10 R20
          rxFull_reg <= 1'b1; noise_reg <= rxNoise_reg; frame_reg <= !stopBit;
        end
      end
    end
  end

endmodule // asu_uart

// >>> common/asu_regs.vh
`ifndef ASU_REGS_VH
`define ASU_REGS_VH
// Register byte offsets.
`define ASU_OFF_DATA    8'h00
`define ASU_OFF_CTRL1   8'h04
`define ASU_OFF_CTRL2   8'h08
`define ASU_OFF_STATUS  8'h0C
`define ASU_OFF_BAUD    8'h10
// Control one fields.
`define ASU_C1_T8       6
`define ASU_C1_WLEN     4
`define ASU_C1_WAKE     3
// Control two fields.
`define ASU_C2_TXEN     3
`define ASU_C2_RXEN     2
`define ASU_C2_SLEEP    1
`define ASU_C2_BRK      0
// Status fields.
`define ASU_ST_TXEMPTY  7
`define ASU_ST_TXDONE   6
`define ASU_ST_RXFULL   5
`define ASU_ST_IDLE     4
`define ASU_ST_OVR      3
`define ASU_ST_NOISE    2
`define ASU_ST_FRAME    1
// Baud fields: divisor in [15:0], divide-by-39 enable in bit 16.
`define ASU_BAUD_DIV39  16
`define ASU_BAUD_RST    17'h00001
`define ASU_DIV39_CNT   6'h26
// Last sample phase of a bit; sixteen samples per bit.
`define ASU_OVERSAMPLE  4'hF
// AXI responses.
`define ASU_RESP_OKAY   2'h0
`define ASU_RESP_SLVERR 2'h2
`endif

// >>> tb/asu_uart_checker.sv
`timescale 1ns/100ps
`include "asu_regs.vh"
// ----------------------------------------------------------------
// Port checker: bus handshakes and transmit line framing.
// ----------------------------------------------------------------
module asu_uart_checker (
  // Clock and reset.
  input logic        clk,
  input logic        rst_n,
  // Register bus.
  input logic        s_axi_awready,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  // Serial line.
  input logic        txd
);
  localparam int BIT_CLKS = 16;  // Clocks per bit at the reset divisor.
  logic [11:0] lowRun;           // Clocks the transmit line has been low.
  logic [4:0]  highRun;          // Clocks high, saturating at one bit time.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Run lengths on the transmit line, so bit timing can be judged.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowRun  <= 12'h000;
      highRun <= 5'h00;
    end else begin
      lowRun  <= txd ? 12'h000 : lowRun + 12'h001;
      highRun <= !txd ? 5'h00 : ((highRun == 5'h10) ? highRun : highRun + 5'h01);
    end
  end
  property p_txd_idle_reset;
    !$past(rst_n) |-> txd;
  endproperty
  a_txd_idle_reset: assert property (p_txd_idle_reset) else $error("txd low after reset");
  property p_low_whole_bits;
    $rose(txd) |-> (lowRun % BIT_CLKS == 0) && (lowRun != 12'h000);
  endproperty
  a_low_whole_bits: assert property (p_low_whole_bits) else $error("txd low run off grid");
  property p_stop_before_start;
    $fell(txd) |-> highRun >= BIT_CLKS;
  endproperty
  a_stop_before_start: assert property (p_stop_before_start) else $error("short stop");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp});
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  property p_r_after_ar;
    $rose(s_axi_rvalid) |-> $past(s_axi_arvalid) && $past(s_axi_arready);
  endproperty
  a_r_after_ar: assert property (p_r_after_ar) else $error("read answer without request");
  property p_b_after_take;
    $rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready);
  endproperty
  a_b_after_take: assert property (p_b_after_take) else $error("write answer too early");
  property p_one_write;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_one_write: assert property (p_one_write) else $error("write taken while answering");
  property p_rresp_map;
    $rose(s_axi_rvalid) |-> s_axi_rresp == ((($past(s_axi_araddr) <= `ASU_OFF_BAUD)
      && ($past(s_axi_araddr) & 8'h03) == 8'h00) ? `ASU_RESP_OKAY : `ASU_RESP_SLVERR);
  endproperty
  a_rresp_map: assert property (p_rresp_map) else $error("read response code wrong");
  c_slverr: cover property ($rose(s_axi_rvalid) && s_axi_rresp == `ASU_RESP_SLVERR);
  c_break: cover property (lowRun == 12'h0A0);
  c_frame: cover property ($fell(txd));
endmodule // asu_uart_checker

bind asu_uart asu_uart_checker i_chk (.*);

// >>> tb/asu_serial_node.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Remote serial node: sends frames on rxd, decodes frames on txd.
// ----------------------------------------------------------------
module asu_serial_node #(
  parameter int BIT_CLKS = 16
) (
  // Clock used only for bit timing.
  input  logic clk,
  // Serial lines seen from the far side.
  input  logic txd,
  output logic rxd
);
  int         wordBits = 8;  // Character length expected on txd.
  logic [8:0] rxQ[$];        // Characters decoded from txd.
  logic       stopQ[$];      // Stop bit level of each decoded frame.
  initial rxd = 1'b1;        // Line rests high between frames.
  // Sends one frame; an optional one-clock glitch mid bit two.
  task automatic send(input logic [8:0] d, input int n, input logic stopBit, input logic glitch);
    rxd <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rxd <= d[i];
      repeat (BIT_CLKS / 2) @(posedge clk);
      if (glitch && i == 2) rxd <= ~d[i];
      @(posedge clk);
      rxd <= d[i];
      repeat (BIT_CLKS / 2 - 1) @(posedge clk);
    end
    rxd <= stopBit;
    repeat (BIT_CLKS) @(posedge clk);
    if (!stopBit) rxd <= 1'b1;  // Frames in one message follow with no gap.
  endtask
  // Decodes frames from the middle of each bit.
  always begin : decode
    logic [8:0] c;
    @(negedge txd);
    c = 9'h000;
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < wordBits; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      c[i] = txd;
    end
    repeat (BIT_CLKS) @(posedge clk);
    stopQ.push_back(txd);
    rxQ.push_back(c);
  end
endmodule // asu_serial_node

// >>> tb/asu_uart_tb.sv
`timescale 1ns/100ps
`include "asu_regs.vh"
// ----------------------------------------------------------------
// Bench: register tasks, serial node and expected values.
// ----------------------------------------------------------------
module asu_uart_tb;
  localparam logic [1:0] OK = `ASU_RESP_OKAY;
  localparam logic [1:0] ERR = `ASU_RESP_SLVERR;
  logic        clk = 1'b0;            // System clock.
  logic        rst_n = 1'b0;          // Reset, active low.
  logic        s_axi_awvalid = 1'b0;  // Bus requests.
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         rxd, txd;
  int          errCount = 0;          // Mismatches seen.
  int          numChecks = 0;         // Comparisons made.
  always #2 clk = ~clk;               // 250 MHz.
  asu_uart i_dut (.*);
  asu_serial_node i_node (.clk(clk), .txd(txd), .rxd(rxd));
  // Ends the run with the verdict.
  task automatic give_verdict;
    if (errCount == 0 && numChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Compares one value and reports a mismatch.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Register write; ready for the answer only after it is offered.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'b0;
        done = 1'b1;
        chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, s_axi_bresp});
      end
    end
  endtask
  // Register read, masked compare of the data.
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    logic done;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'b0;
        done = 1'b1;
        chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, s_axi_rresp});
        chk($sformatf("rdata %h", a), e, s_axi_rdata & m);
      end
    end
  endtask
  // Waits for a character from the transmit line and compares it.
  task automatic getc(input logic [8:0] e);
    for (int i = 0; i < 2000 && i_node.rxQ.size() == 0; i++) @(posedge clk);
    chk("txchar", {23'h0, e}, {23'h0, i_node.rxQ.pop_front()});
    chk("stopbit", 32'h1, {31'h0, i_node.stopQ.pop_front()});
  endtask
  // Watchdog against a hung handshake or line.
  initial begin
    repeat (30000) @(posedge clk);
    errCount++;
    give_verdict;
  end
  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`ASU_OFF_CTRL2, 32'hFF, 32'h00, OK);
    rd(`ASU_OFF_STATUS, 32'hC0, 32'hC0, OK);
    wr(`ASU_OFF_BAUD, 32'h10001, OK);
    rd(`ASU_OFF_BAUD, 32'h1FFFF, 32'h10001, OK);
    wr(`ASU_OFF_BAUD, 32'h00001, OK);
    wr(8'h14, 32'h0, ERR);
    rd(8'h14, 32'h0, 32'h0, ERR);
    wr(`ASU_OFF_CTRL2, 32'h08, OK);
    wr(`ASU_OFF_DATA, 32'hA5, OK);
    repeat (120) begin
      @(posedge clk);
      chk("preamble", 32'h1, {31'h0, txd});
    end
    repeat (60) @(posedge clk);
    rd(`ASU_OFF_STATUS, 32'h80, 32'h80, OK);
    wr(`ASU_OFF_DATA, 32'h3C, OK);
    rd(`ASU_OFF_STATUS, 32'h80, 32'h00, OK);
    getc(9'h0A5);
    getc(9'h03C);
    wr(`ASU_OFF_CTRL1, 32'h50, OK);
    i_node.wordBits = 9;
    wr(`ASU_OFF_DATA, 32'h55, OK);
    getc(9'h155);
    wr(`ASU_OFF_CTRL1, 32'h00, OK);
    i_node.wordBits = 8;
    wr(`ASU_OFF_CTRL2, 32'h09, OK);
    repeat (200) @(posedge clk);
    chk("break", 32'h0, {31'h0, txd});
    wr(`ASU_OFF_CTRL2, 32'h0C, OK);
    repeat (500) @(posedge clk);
    i_node.rxQ.delete();
    i_node.stopQ.delete();
    i_node.send(9'h096, 8, 1'b1, 1'b0);
    rd(`ASU_OFF_STATUS, 32'h26, 32'h20, OK);
    rd(`ASU_OFF_DATA, 32'hFF, 32'h96, OK);
    i_node.send(9'h05A, 8, 1'b1, 1'b1);
    rd(`ASU_OFF_STATUS, 32'h24, 32'h24, OK);
    rd(`ASU_OFF_DATA, 32'hFF, 32'h5A, OK);
    i_node.send(9'h077, 8, 1'b0, 1'b0);
    rd(`ASU_OFF_STATUS, 32'h22, 32'h22, OK);
    rd(`ASU_OFF_DATA, 32'hFF, 32'h77, OK);
    wr(`ASU_OFF_CTRL1, 32'h08, OK);
    wr(`ASU_OFF_CTRL2, 32'h0E, OK);
    wr(`ASU_OFF_CTRL2, 32'h0C, OK);
    rd(`ASU_OFF_CTRL2, 32'h02, 32'h00, OK);
    wr(`ASU_OFF_CTRL2, 32'h0E, OK);
    i_node.send(9'h012, 8, 1'b1, 1'b0);
    repeat (200) @(posedge clk);
    rd(`ASU_OFF_STATUS, 32'h3E, 32'h00, OK);
    rd(`ASU_OFF_CTRL2, 32'h02, 32'h02, OK);
    i_node.send(9'h081, 8, 1'b1, 1'b0);
    rd(`ASU_OFF_CTRL2, 32'h02, 32'h00, OK);
    rd(`ASU_OFF_STATUS, 32'h20, 32'h20, OK);
    rd(`ASU_OFF_DATA, 32'hFF, 32'h81, OK);
    wr(`ASU_OFF_CTRL1, 32'h00, OK);
    fork
      i_node.send(9'h033, 8, 1'b1, 1'b0);
      begin
        repeat (48) @(posedge clk);
        wr(`ASU_OFF_CTRL2, 32'h0E, OK);
      end
    join
    rd(`ASU_OFF_STATUS, 32'h20, 32'h00, OK);
    rd(`ASU_OFF_CTRL2, 32'h02, 32'h02, OK);
    repeat (200) @(posedge clk);
    rd(`ASU_OFF_CTRL2, 32'h02, 32'h00, OK);
    i_node.send(9'h044, 8, 1'b1, 1'b0);
    rd(`ASU_OFF_DATA, 32'hFF, 32'h44, OK);
    wr(`ASU_OFF_CTRL1, 32'h10, OK);
    i_node.send(9'h1A5, 9, 1'b1, 1'b0);
    rd(`ASU_OFF_CTRL1, 32'h80, 32'h80, OK);
    rd(`ASU_OFF_DATA, 32'hFF, 32'hA5, OK);
    give_verdict;
  end
endmodule // asu_uart_tb
